//--- design/drgs_rx_gearing.sv
// Receive DDR gearing with per-lane word slip and clock-path lock model
`timescale 1ns/100ps

module drgs_rx_gearing import drgs_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic fast_bank_clock,
	input wire logic [`DRGS_LANES-1:0] rx_data,
	input wire logic fast_clock_pause,
	input wire logic [`DRGS_LANES-1:0] lane_slip_request,
	input wire drgs_cfg_s cfg,
	output drgs_word_s [`DRGS_LANES-1:0] lane_parallel_word,
	output logic [`DRGS_LANES-1:0] lane_word_valid,
	output logic lane_fabric_clock,
	output logic regional_clock_buffer,
	output logic global_clock_out,
	output logic tx_resync_pulse,
	output logic pll_lock,
	output logic pll_powerdown,
	output logic [3:0] pll_mult_factor
);

	// ****************************************
	// Functions
	// ****************************************
	function automatic drgs_cnt_t word_bits(input logic [1:0] ratio);
		case (ratio)
			`DRGS_RATIO_X2: word_bits = `DRGS_WBITS_X2;
			`DRGS_RATIO_X3P5: word_bits = `DRGS_WBITS_X3P5;
			`DRGS_RATIO_X4: word_bits = `DRGS_WBITS_X4;
			default: word_bits = `DRGS_WBITS_X5;
		endcase
	endfunction

	function automatic drgs_cnt_t slip_bits(input logic [1:0] ratio);
		slip_bits = (ratio == `DRGS_RATIO_X3P5) ? `DRGS_SLIP_X3P5 : `DRGS_SLIP_OTHER;
	endfunction

	// ****************************************
	// Link-domain reset release
	// ****************************************
	logic link_rst_s1_r;
	logic link_rst_n_r;

	always_ff @(posedge fast_bank_clock or negedge rst_n) begin
		if (!rst_n) begin
			link_rst_s1_r <= 1'b0;
			link_rst_n_r <= 1'b0;
		end else begin
			link_rst_s1_r <= 1'b1;
			link_rst_n_r <= link_rst_s1_r;
		end
	end

	// ****************************************
	// Synchronisers into the link domain
	// ****************************************
	drgs_cfg_s cfg_s1_r;
	drgs_cfg_s cfg_l_r;
	logic pause_s1_r;
	logic pause_s2_r;
	logic pause_s3_r;
	logic [`DRGS_LANES-1:0] slip_s1_r;
	logic [`DRGS_LANES-1:0] slip_s2_r;
	logic [`DRGS_LANES-1:0] slip_s3_r;

	always_ff @(posedge fast_bank_clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_s1_r <= '0;
			cfg_l_r <= '0;
			pause_s1_r <= 1'b0;
			pause_s2_r <= 1'b0;
			pause_s3_r <= 1'b0;
			slip_s1_r <= '0;
			slip_s2_r <= '0;
			slip_s3_r <= '0;
		end else begin
			cfg_s1_r <= cfg;
			cfg_l_r <= cfg_s1_r;
			pause_s1_r <= fast_clock_pause;
			pause_s2_r <= pause_s1_r;
			pause_s3_r <= pause_s2_r;
			slip_s1_r <= lane_slip_request;
			slip_s2_r <= slip_s1_r;
			slip_s3_r <= slip_s2_r;
		end
	end

	logic pause_go;
	logic [`DRGS_LANES-1:0] slip_go;
	logic [1:0] ratio_eff;
	logic phase_eff;
	drgs_cnt_t wbits;
	drgs_cnt_t sbits;

	assign pause_go = pause_s2_r ^ pause_s3_r;
	assign slip_go = slip_s2_r & ~slip_s3_r;
	// Fractional mode: fast clock at twice the forwarded rate gives four bits per fabric cycle
	assign ratio_eff = (cfg_l_r.mode == DRGS_MODE_FRACTIONAL) ? `DRGS_RATIO_X2 : cfg_l_r.ratio;
	assign phase_eff = (cfg_l_r.mode == DRGS_MODE_DYNAMIC) & cfg_l_r.sample_phase;
	assign wbits = word_bits(ratio_eff);
	assign sbits = slip_bits(ratio_eff);

	// ****************************************
	// DDR capture
	// ****************************************
	logic [`DRGS_LANES-1:0] rise_r;
	logic [`DRGS_LANES-1:0] fall_r;
	logic [`DRGS_LANES-1:0] fall_prev_r;

	always_ff @(negedge fast_bank_clock or negedge rst_n) begin
		if (!rst_n) begin
			fall_r <= '0;
		end else begin
			fall_r <= rx_data;
		end
	end

	always_ff @(posedge fast_bank_clock or negedge rst_n) begin
		if (!rst_n) begin
			rise_r <= '0;
			fall_prev_r <= '0;
		end else begin
			rise_r <= rx_data;
			fall_prev_r <= fall_r;
		end
	end

	// ****************************************
	// Per-lane gearing
	// ****************************************
	logic [`DRGS_HIST-1:0] hist_r [`DRGS_LANES];
	drgs_cnt_t cnt_r [`DRGS_LANES];
	drgs_cnt_t slip_total_r [`DRGS_LANES];
	logic [`DRGS_HIST-1:0] hist_nxt [`DRGS_LANES];
	drgs_cnt_t cnt_nxt [`DRGS_LANES];
	drgs_cnt_t avail [`DRGS_LANES];
	logic [`DRGS_LANES-1:0] emit;
	drgs_word_s word_nxt [`DRGS_LANES];

	always_comb begin
		for (int l = 0; l < `DRGS_LANES; l++) begin
			// Older bit goes in first so it lands at the higher history position
			hist_nxt[l] = phase_eff ? {hist_r[l][`DRGS_HIST-3:0], fall_prev_r[l], rise_r[l]}
				: {hist_r[l][`DRGS_HIST-3:0], rise_r[l], fall_r[l]};
			avail[l] = cnt_r[l] + `DRGS_BITS_PER_CYC - (slip_go[l] ? sbits : 4'h0);
			emit[l] = (avail[l] >= wbits);
			cnt_nxt[l] = emit[l] ? avail[l] - wbits : avail[l];
			word_nxt[l] = '0;
			for (int i = 0; i < `DRGS_WMAX; i++) begin
				if (emit[l] && (4'(i) < wbits)) begin
					word_nxt[l].bits[i] = hist_nxt[l][4'(avail[l] - 4'h1 - 4'(i))];
				end
			end
		end
	end

	always_ff @(posedge fast_bank_clock or negedge link_rst_n_r) begin
		if (!link_rst_n_r) begin
			for (int l = 0; l < `DRGS_LANES; l++) begin
				hist_r[l] <= '0;
				cnt_r[l] <= '0;
				slip_total_r[l] <= '0;
			end
		end else begin
			for (int l = 0; l < `DRGS_LANES; l++) begin
				if (pause_go) begin
					hist_r[l] <= '0;
					cnt_r[l] <= '0;
					slip_total_r[l] <= '0;
				end else begin
					hist_r[l] <= hist_nxt[l];
					cnt_r[l] <= cnt_nxt[l];
					if (slip_go[l]) begin
						slip_total_r[l] <= slip_total_r[l] + sbits;
					end
				end
			end
		end
	end

	always_ff @(posedge fast_bank_clock or negedge link_rst_n_r) begin
		if (!link_rst_n_r) begin
			lane_word_valid <= '0;
			for (int l = 0; l < `DRGS_LANES; l++) begin
				lane_parallel_word[l] <= '0;
			end
		end else begin
			lane_word_valid <= pause_go ? '0 : emit;
			for (int l = 0; l < `DRGS_LANES; l++) begin
				if (emit[l] && !pause_go) begin
					lane_parallel_word[l] <= word_nxt[l];
				end
			end
		end
	end

	// ****************************************
	// Lane fabric clock and transmit resync
	// ****************************************
	drgs_cnt_t since_r;
	logic fab_nxt;

	assign fab_nxt = emit[0] | ((since_r + 4'h1) < (wbits >> 2));

	always_ff @(posedge fast_bank_clock or negedge link_rst_n_r) begin
		if (!link_rst_n_r) begin
			since_r <= '0;
			lane_fabric_clock <= 1'b0;
			regional_clock_buffer <= 1'b0;
			global_clock_out <= 1'b0;
			tx_resync_pulse <= 1'b0;
		end else begin
			since_r <= (emit[0] || pause_go) ? 4'h0 : since_r + 4'h1;
			lane_fabric_clock <= fab_nxt & ~pause_go;
			regional_clock_buffer <= fab_nxt & ~pause_go & ~cfg_l_r.net_global;
			global_clock_out <= fab_nxt & ~pause_go & cfg_l_r.net_global;
			tx_resync_pulse <= pause_go;
		end
	end

	// ****************************************
	// Clock-path lock model
	// ****************************************
	logic beat_r;
	logic beat_s1_r;
	logic beat_s2_r;
	logic beat_s3_r;
	drgs_cfg_s cfg_s_s1_r;
	drgs_cfg_s cfg_s_r;
	drgs_lock_e lk_r;
	logic [`DRGS_TMR_W-1:0] lock_tmr_r;
	logic [`DRGS_TMR_W-1:0] idle_tmr_r;
	logic beat_seen;
	logic frac_mode;

	always_ff @(posedge fast_bank_clock or negedge link_rst_n_r) begin
		if (!link_rst_n_r) begin
			beat_r <= 1'b0;
		end else begin
			beat_r <= ~beat_r;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			beat_s1_r <= 1'b0;
			beat_s2_r <= 1'b0;
			beat_s3_r <= 1'b0;
			cfg_s_s1_r <= '0;
			cfg_s_r <= '0;
		end else begin
			beat_s1_r <= beat_r;
			beat_s2_r <= beat_s1_r;
			beat_s3_r <= beat_s2_r;
			cfg_s_s1_r <= cfg;
			cfg_s_r <= cfg_s_s1_r;
		end
	end

	assign beat_seen = beat_s2_r ^ beat_s3_r;
	assign frac_mode = (cfg_s_r.mode == DRGS_MODE_FRACTIONAL);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lk_r <= DRGS_LK_PWRDN;
			lock_tmr_r <= '0;
			idle_tmr_r <= '0;
		end else begin
			idle_tmr_r <= beat_seen ? '0 : ((idle_tmr_r < `DRGS_IDLE_CYC) ? idle_tmr_r + 11'h001 : idle_tmr_r);
			case (lk_r)
				DRGS_LK_PWRDN: begin
					lock_tmr_r <= '0;
					if (frac_mode) begin
						lk_r <= DRGS_LK_LOCKING;
					end
				end
				DRGS_LK_LOCKING: begin
					if (!frac_mode) begin
						lk_r <= DRGS_LK_PWRDN;
					end else if (idle_tmr_r >= `DRGS_IDLE_CYC) begin
						lock_tmr_r <= '0;
					end else if (lock_tmr_r == `DRGS_TMR_W'(`DRGS_LOCK_CYC - 1)) begin
						lk_r <= DRGS_LK_LOCKED;
					end else begin
						lock_tmr_r <= lock_tmr_r + 11'h001;
					end
				end
				DRGS_LK_LOCKED: begin
					lock_tmr_r <= '0;
					if (!frac_mode) begin
						lk_r <= DRGS_LK_PWRDN;
					end else if (idle_tmr_r >= `DRGS_IDLE_CYC) begin
						lk_r <= DRGS_LK_LOCKING;
					end
				end
				default: begin
					lk_r <= DRGS_LK_PWRDN;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pll_lock <= 1'b0;
			pll_powerdown <= 1'b1;
			pll_mult_factor <= `DRGS_FACT_2;
		end else begin
			pll_lock <= (lk_r == DRGS_LK_LOCKED);
			pll_powerdown <= (lk_r == DRGS_LK_PWRDN);
			case (cfg_s_r.mult)
				`DRGS_MULT_2: pll_mult_factor <= `DRGS_FACT_2;
				`DRGS_MULT_4: pll_mult_factor <= `DRGS_FACT_4;
				`DRGS_MULT_8: pll_mult_factor <= `DRGS_FACT_8;
				default: pll_mult_factor <= `DRGS_FACT_10;
			endcase
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_slip_rise;
		slip_s2_r[0] && !slip_s3_r[0] && !pause_go;
	endsequence

	sequence s_pause_edge;
		pause_s2_r != pause_s3_r;
	endsequence

	a_slip_adds_offset: assert property (@(posedge fast_bank_clock) disable iff (!link_rst_n_r)
		s_slip_rise |=> slip_total_r[0] == $past(slip_total_r[0]) + $past(sbits))
		else $error("slip step not accumulated");

	a_slip_amount: assert property (@(posedge fast_bank_clock) disable iff (!link_rst_n_r)
		(s_slip_rise and (ratio_eff == `DRGS_RATIO_X3P5)) |=> slip_total_r[0] == $past(slip_total_r[0]) + `DRGS_SLIP_X3P5)
		else $error("slip amount wrong for ratio");

	a_pause_clears: assert property (@(posedge fast_bank_clock) disable iff (!link_rst_n_r)
		s_pause_edge |=> (cnt_r[0] == 4'h0) && (slip_total_r[0] == 4'h0) && !lane_word_valid[0])
		else $error("pause did not clear gearing");

	a_tx_resync_pulse: assert property (@(posedge fast_bank_clock) disable iff (!link_rst_n_r)
		s_pause_edge ##1 !pause_go |-> tx_resync_pulse ##1 !tx_resync_pulse)
		else $error("transmit resync pulse wrong");

	a_word_upper_zero: assert property (@(posedge fast_bank_clock) disable iff (!link_rst_n_r)
		lane_word_valid[0] && $stable(ratio_eff) && (ratio_eff == `DRGS_RATIO_X2) |-> lane_parallel_word[0].bits[9:4] == 6'h00)
		else $error("word wider than ratio");

	a_word_spacing: assert property (@(posedge fast_bank_clock) disable iff (!link_rst_n_r)
		lane_word_valid[0] && (ratio_eff == `DRGS_RATIO_X5) && $stable(ratio_eff) |=> !lane_word_valid[0] [*3])
		else $error("words too close for ratio five");

	a_frac_fixed_phase: assert property (@(posedge fast_bank_clock) disable iff (!link_rst_n_r)
		lane_word_valid[0] && (cfg_l_r.mode == DRGS_MODE_FRACTIONAL) && $stable(cfg_l_r.mode) |-> !phase_eff && (lane_parallel_word[0].bits[9:4] == 6'h00))
		else $error("fractional mode not fixed");

	a_net_exclusive: assert property (@(posedge fast_bank_clock) disable iff (!link_rst_n_r)
		!(regional_clock_buffer && global_clock_out) && (lane_fabric_clock == (regional_clock_buffer | global_clock_out)))
		else $error("clock network select wrong");

	a_lock_needs_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(pll_lock) |-> $past(lk_r == DRGS_LK_LOCKING, 2) && !pll_powerdown)
		else $error("lock without locking phase");

	a_powerdown_unlocked: assert property (@(posedge sys_clk) disable iff (!rst_n)
		pll_powerdown |-> !pll_lock)
		else $error("locked while powered down");

	a_mult_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(cfg_s_r.mult == `DRGS_MULT_10) |=> pll_mult_factor == `DRGS_FACT_10)
		else $error("multiplier factor wrong");

endmodule

//--- include/drgs_map.svh
// Constants for the DDR receive gearing and slip block
`ifndef DRGS_MAP_SVH
`define DRGS_MAP_SVH

// ****************************************
// Sizes
// ****************************************
`define DRGS_LANES 11
`define DRGS_WMAX 10
`define DRGS_HIST 12
`define DRGS_CNT_W 4

// ****************************************
// Ratio codes and word widths in bits per lane
// ****************************************
`define DRGS_RATIO_X2 2'h0
`define DRGS_RATIO_X3P5 2'h1
`define DRGS_RATIO_X4 2'h2
`define DRGS_RATIO_X5 2'h3
`define DRGS_WBITS_X2 4'h4
`define DRGS_WBITS_X3P5 4'h7
`define DRGS_WBITS_X4 4'h8
`define DRGS_WBITS_X5 4'hA
`define DRGS_BITS_PER_CYC 4'h2
`define DRGS_SLIP_X3P5 4'h2
`define DRGS_SLIP_OTHER 4'h1

// ****************************************
// Clock multiplier codes and factors
// ****************************************
`define DRGS_MULT_2 2'h0
`define DRGS_MULT_4 2'h1
`define DRGS_MULT_8 2'h2
`define DRGS_MULT_10 2'h3
`define DRGS_FACT_2 4'h2
`define DRGS_FACT_4 4'h4
`define DRGS_FACT_8 4'h8
`define DRGS_FACT_10 4'hA

// ****************************************
// Timing
// ****************************************
`define DRGS_SYS_PERIOD_NS 10
`define DRGS_LOCK_TIME_NS 10000
`define DRGS_LOCK_CYC ((`DRGS_LOCK_TIME_NS + `DRGS_SYS_PERIOD_NS - 1) / `DRGS_SYS_PERIOD_NS)
`define DRGS_IDLE_CYC 11'h040
`define DRGS_TMR_W 11

`endif

//--- include/drgs_pkg.sv
// Types for the DDR receive gearing and slip block
`include "drgs_map.svh"

package drgs_pkg;

	typedef enum logic [0:0] {
		DRGS_MODE_FRACTIONAL = 1'b0,
		DRGS_MODE_DYNAMIC = 1'b1
	} drgs_mode_e;

	typedef enum logic [2:0] {
		DRGS_LK_PWRDN = 3'b001,
		DRGS_LK_LOCKING = 3'b010,
		DRGS_LK_LOCKED = 3'b100
	} drgs_lock_e;

	typedef struct packed {
		drgs_mode_e mode;
		logic [1:0] ratio;
		logic [1:0] mult;
		logic sample_phase;
		logic net_global;
	} drgs_cfg_s;

	typedef struct packed {
		logic [`DRGS_WMAX-1:0] bits;
	} drgs_word_s;

	typedef logic [`DRGS_CNT_W-1:0] drgs_cnt_t;

endpackage

//--- verification/drgs_tx_model.sv
// Source-synchronous DDR transmitter driving forwarded clock and lane data
`timescale 1ns/100ps

module drgs_tx_model (
	input wire logic run,
	input wire logic [10:0] pattern,
	output logic fast_bank_clock,
	output logic [10:0] rx_data
);
	initial begin
		fast_bank_clock = 1'b0;
		rx_data = 11'h000;
		#3.7;
		forever begin
			#80;
			// Clock stands still between frames; data lines then keep changing
			if (run)
				fast_bank_clock = ~fast_bank_clock;
			else
				rx_data = ~rx_data;
		end
	end

	// Data changes mid-bit so both clock edges land inside the valid window
	always @(fast_bank_clock)
		rx_data <= #40 pattern;
endmodule

//--- verification/ddr_receive_gearing_slip_test.sv
// Self-checking bench for the DDR receive gearing and slip block
`timescale 1ns/100ps
`include "drgs_map.svh"

module ddr_receive_gearing_slip_test import drgs_pkg::*;;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic fast_clock_pause = 1'b0;
	logic [`DRGS_LANES-1:0] lane_slip_request = '0;
	drgs_cfg_s cfg = '0;
	logic run = 1'b1;
	logic [10:0] pat = 11'h000;
	logic fast_bank_clock;
	logic [`DRGS_LANES-1:0] rx_data;
	drgs_word_s [`DRGS_LANES-1:0] lane_parallel_word;
	logic [`DRGS_LANES-1:0] lane_word_valid;
	logic lane_fabric_clock;
	logic regional_clock_buffer;
	logic global_clock_out;
	logic tx_resync_pulse;
	logic pll_lock;
	logic pll_powerdown;
	logic [3:0] pll_mult_factor;
	int fail_count = 0;
	int total_checks = 0;
	int seed = 32'h821B6337;
	int pos[11] = '{default: -1};
	int pnd[11] = '{default: 0};
	int wbt[4] = '{4, 7, 8, 10};
	int fac[4] = '{2, 4, 8, 10};
	int wb = 4;
	int ph = 0;
	int quiet = 1;
	int nslip = 0;
	int npz = 0;
	int nres = 0;
	int ncr = 0;
	int ncg = 0;
	int ncf = 0;
	int nexp = 0;
	int cyc = 0;
	int sl;
	bit hist[11][$];

	drgs_tx_model u_tx (.run(run), .pattern(pat), .fast_bank_clock(fast_bank_clock), .rx_data(rx_data));

	drgs_rx_gearing u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .fast_bank_clock(fast_bank_clock),
		.rx_data(rx_data), .fast_clock_pause(fast_clock_pause), .lane_slip_request(lane_slip_request),
		.cfg(cfg), .lane_parallel_word(lane_parallel_word), .lane_word_valid(lane_word_valid),
		.lane_fabric_clock(lane_fabric_clock), .regional_clock_buffer(regional_clock_buffer),
		.global_clock_out(global_clock_out), .tx_resync_pulse(tx_resync_pulse), .pll_lock(pll_lock),
		.pll_powerdown(pll_powerdown), .pll_mult_factor(pll_mult_factor));

	always #5 sys_clk = ~sys_clk;

	always @(fast_bank_clock) begin
		#20;
		pat = 11'($random(seed));
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			final_report();
		end
	end

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	function automatic logic [9:0] hw(int l, int p);
		hw = '0;
		for (int i = 0; i < wb; i++)
			hw[i] = hist[l][p + i];
	endfunction

	// Model word: wb sent bits in time order; a pending slip moves the boundary later
	task automatic word_check(int l);
		int n;
		int hit;
		int q;
		logic [9:0] w;
		n = 0;
		hit = 0;
		q = pos[l] + pnd[l];
		w = lane_parallel_word[l].bits;
		if (pos[l] < 0) begin
			for (int p = hist[l].size() - wb - 12; p <= hist[l].size() - wb; p++) begin
				if (p >= 0 && hw(l, p) === w) begin
					n++;
					hit = p;
				end
			end
			if (n == 1 && wb % 2 == 0)
				check("word_start_parity", hit % 2, ph);
			pos[l] = (n == 1) ? hit + wb : -1;
		end
		else begin
			// Keep the old boundary while it still matches; a later word settles a chance match
			if (pnd[l] > 0 && hw(l, pos[l]) !== w && hw(l, q) === w) begin
				nslip++;
				pos[l] = q;
				pnd[l] = 0;
			end
			if (pos[l] >= 0) begin
				check("lane_word", w, hw(l, pos[l]));
				pos[l] += wb;
			end
		end
	endtask

	always @(fast_bank_clock) begin
		if (fast_bank_clock || hist[0].size() > 0) begin
			for (int l = 0; l < 11; l++)
				hist[l].push_back(rx_data[l]);
		end
		if (!fast_bank_clock) begin
			nres += (tx_resync_pulse === 1'b1);
			ncr += (regional_clock_buffer === 1'b1);
			ncg += (global_clock_out === 1'b1);
			ncf += (lane_fabric_clock === 1'b1);
			for (int l = 0; l < 11; l++) begin
				if (rst_n && quiet == 0 && lane_word_valid[l] === 1'b1)
					word_check(l);
			end
		end
	end

	task automatic sc(int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic lk(int n);
		repeat (n) @(posedge fast_bank_clock);
		@(negedge sys_clk);
	endtask

	// Words around a pause are ignored, then every lane is anchored afresh
	task automatic pause_ev();
		quiet = 1;
		npz++;
		fast_clock_pause = ~fast_clock_pause;
		lk(8);
		pos = '{default: -1};
		pnd = '{default: 0};
		quiet = 0;
	endtask

	task automatic done(string t);
		$display("%s done: checks %0d mismatches %0d", t, total_checks, fail_count);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		sc(3);
		check("pd_in_reset", pll_powerdown, 1);
		check("lock_in_reset", pll_lock, 0);
		sc(3);
		rst_n = 1'b1;
		sc(900);
		check("lock_early", pll_lock, 0);
		sc(120);
		check("lock_up", pll_lock, 1);
		run = 1'b0;
		sc(100);
		check("lock_lost", pll_lock, 0);
		run = 1'b1;
		sc(1040);
		check("relock", pll_lock, 1);
		done("lock");
		pause_ev();
		lk(30);
		for (int m = 0; m < 4; m++) begin
			cfg.mult = 2'(m);
			sc(6);
			check("mult_factor", pll_mult_factor, fac[m]);
		end
		for (int g = 0; g < 2; g++) begin
			cfg.net_global = g[0];
			lk(4);
			ncr = 0;
			ncg = 0;
			ncf = 0;
			lk(20);
			check("fabric_clock_count", ncf, ncr + ncg);
			check("regional_active", ncr > 0, g == 0);
			check("global_active", ncg > 0, g == 1);
		end
		done("fractional");
		quiet = 1;
		cfg.mode = DRGS_MODE_DYNAMIC;
		sc(6);
		check("pd_dynamic", pll_powerdown, 1);
		check("lock_dynamic", pll_lock, 0);
		for (int r = 0; r < 4; r++) begin
			quiet = 1;
			cfg.ratio = 2'(r);
			cfg.sample_phase = (r == 2);
			wb = wbt[r];
			ph = (r == 2);
			sc(4);
			pause_ev();
			lk(20);
			sl = $unsigned($random(seed)) % 11;
			// Lane 0 always slips so the lane-0 slip assertions see every ratio
			pnd[0] = (r == 1) ? 2 : 1;
			pnd[sl] = (r == 1) ? 2 : 1;
			nexp += (sl == 0) ? 1 : 2;
			lane_slip_request[0] = 1'b1;
			lane_slip_request[sl] = 1'b1;
			lk(12);
			lane_slip_request = '0;
			lk(12);
			check("slip_taken", nslip, nexp);
			pause_ev();
			lk(20);
			check("resync_count", nres, npz);
			done("dynamic ratio");
		end
		rst_n = 1'b0;
		sc(3);
		check("valid_in_reset", lane_word_valid, 0);
		check("pd_reset_again", pll_powerdown, 1);
		done("reset");
		final_report();
	end
endmodule
